// >>> hdl/watchdog_control_bits.sv
// Watchdog control register with protected write, status flag and timeout response.
// Assumes the core presents register writes as one-cycle strobes, one per instruction.
// Overview of operation
// - interrupt mode raises unmaskable high-priority interrupt
// - timeout sets flag; survives watchdog reset
// - refresh before expiry, else reset/interrupt
// - arm clears on write0, wdreset, reset, monitor
// - write accepted only right after unlock
// - period is 2^prescale times 512 ticks
// - prescale 8 forces immediate reset
`timescale 1ns/100ps
module watchdog_control_bits
  import watchdog_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,            // External hardware reset
  input  wire logic       xtal_tick_i,      // One pulse per crystal period
  input  wire logic       reg_write_i,      // Write strobe to control register
  input  wire logic       instr_done_i,     // Pulse at each completed instruction
  input  wire logic [7:0] reg_wdata_i,      // Write data
  input  wire logic       supply_monitor_i, // Supply monitor interrupt pulse
  output logic      [7:0] reg_rdata_o,      // Control register read value
  output logic            timeout_irq_o,    // High-priority unmaskable interrupt pulse
  output logic            watchdog_reset_o  // Watchdog reset request pulse
);
  logic [3:0] timeout_prescale;     // Prescale code
  logic       timeout_irq_select;   // 1 selects interrupt response
  logic       timeout_flag;         // Sticky timeout status
  logic       watchdog_arm;         // Enable / refresh bit
  logic       write_unlock;         // Unlock for next instruction
  logic       unlock_armed;         // Unlock window open for next instruction
  logic       write_accept;         // Protected write taken this cycle
  logic       arm_restart;          // Software refresh
  logic       expired;              // Timeout pulse from counter
  logic       immediate;            // Immediate reset selection
  logic       wd_reset_event;       // Watchdog reset this cycle
  logic [3:0] wr_prescale;          // Prescale field of write data
  logic       wr_irq_select;        // Response select field of write data
  logic       wr_arm;               // Arm field of write data
  logic       wr_unlock;            // Unlock field of write data
  logic       run_counter;          // Counter runs on a timed code
  logic       arm_clear;            // Supply monitor or watchdog reset clear of the arm bit
  logic       flag_set;             // Timeout of either kind
  logic       irq_event;            // Interrupt response this cycle
  logic [7:0] next_read;            // Register image for the read port

  // Write is accepted only in the instruction after unlock
  // gated protected write
  assign write_accept   = reg_write_i && unlock_armed;
  assign arm_restart    = write_accept && wr_arm;
  assign immediate      = watchdog_arm && (timeout_prescale == PRESCALE_IMMEDIATE);
  assign wd_reset_event = (expired && !timeout_irq_select) || immediate;

  // Split the write byte into its fields; the flag bit is never taken
  always_comb begin
    wr_prescale   = reg_wdata_i[PRESCALE_LSB +: PRESCALE_WIDTH];  // Upper nibble
    wr_irq_select = reg_wdata_i[BIT_IRQ_SELECT];                  // Response select
    wr_arm        = reg_wdata_i[BIT_WATCHDOG_ARM];                // Enable / refresh
    wr_unlock     = reg_wdata_i[BIT_WRITE_UNLOCK];                // Unlock request
  end

  // Counter only runs while armed on a timed code
  // timed codes only
  always_comb begin
    run_counter = 1'b0;                 // Stopped by default
    if (watchdog_arm) begin
      // Codes 8 and above have no timed period
      run_counter = (timeout_prescale <= PRESCALE_MAX_TIMED);
    end
  end

  // Hardware clear sources of the arm bit
  // clear on reset and monitor events
  always_comb begin
    arm_clear = 1'b0;                   // Nothing clears by default
    if (supply_monitor_i) begin
      // Supply monitor interrupt
      arm_clear = 1'b1;
    end else if (wd_reset_event) begin
      // Watchdog reset: expiry in reset response mode or immediate code
      arm_clear = 1'b1;
    end
  end

  // Timeout status source
  // any timeout sets flag
  always_comb begin
    flag_set = expired || immediate;    // Timed or immediate
  end

  // Interrupt response; no mask input exists, so it cannot be masked
  // interrupt on timed expiry
  always_comb begin
    irq_event = 1'b0;                   // Quiet by default
    if (expired && timeout_irq_select) begin
      // Immediate code always resets instead
      irq_event = !immediate;
    end
  end

  // Register image as software reads it
  always_comb begin
    next_read                                 = CONTROL_RESET;      // Reset image, every bit overwritten below
    next_read[PRESCALE_LSB +: PRESCALE_WIDTH] = timeout_prescale;   // Prescale field
    next_read[BIT_IRQ_SELECT]                 = timeout_irq_select; // Response select
    next_read[BIT_TIMEOUT_FLAG]               = timeout_flag;       // Status flag
    next_read[BIT_WATCHDOG_ARM]               = watchdog_arm;       // Arm bit
    next_read[BIT_WRITE_UNLOCK]               = write_unlock;       // Unlock bit
  end

  // Timeout counter
  watchdog_timeout_counter u_counter (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .run_i       (run_counter),
    .restart_i   (arm_restart),
    .xtal_tick_i (xtal_tick_i),
    .prescale_i  (timeout_prescale),
    .expired_o   (expired)
  );

  // Unlock bit: any write sets or clears it, cleared after one instruction
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      write_unlock <= 1'b0;
      unlock_armed <= 1'b0;
    end else if (reg_write_i && !unlock_armed) begin
      // Unlock write only touches this bit
      write_unlock <= wr_unlock;
      unlock_armed <= wr_unlock;
    end else if (instr_done_i || write_accept) begin
      // Window closes after the next instruction
      write_unlock <= 1'b0;
      unlock_armed <= 1'b0;
    end
  end

  // Prescale and response select
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      timeout_prescale   <= CONTROL_RESET[PRESCALE_LSB +: PRESCALE_WIDTH];
      timeout_irq_select <= CONTROL_RESET[BIT_IRQ_SELECT];
    end else if (write_accept) begin
      timeout_prescale   <= wr_prescale;
      timeout_irq_select <= wr_irq_select;
    end
  end

  // Arm bit
  // arm clear sources
  always_ff @(posedge core_clk_i) begin
    if (rst_i || arm_clear) begin
      // Hardware clears win over a software write
      watchdog_arm <= 1'b0;
    end else if (write_accept) begin
      // Software write of 0 disarms, 1 refreshes
      watchdog_arm <= wr_arm;
    end
  end

  // Status flag: only hardware reset clears it; reset wins over set
  // sticky timeout flag
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      timeout_flag <= 1'b0;
    end else if (flag_set) begin
      timeout_flag <= 1'b1;
    end
  end

  // Interrupt pulse
  // interrupt response
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      // Quiet through hardware reset
      timeout_irq_o <= 1'b0;
    end else begin
      // One pulse per timed expiry
      timeout_irq_o <= irq_event;
    end
  end

  // Watchdog reset pulse; the same event clears the arm bit through arm_clear in the arm bit block
  // reset response
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      // Quiet through hardware reset
      watchdog_reset_o <= 1'b0;
    end else begin
      // Expiry in reset mode or immediate code
      watchdog_reset_o <= wd_reset_event;
    end
  end

  // Read value
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= CONTROL_RESET;
    end else begin
      reg_rdata_o <= next_read;
    end
  end
endmodule

// >>> hdl/watchdog_pkg.sv
// Constants shared by the watchdog control block and its timeout counter.
// Assumes a 250 MHz core clock and a 32.768 kHz crystal tick input.
package watchdog_pkg;
  // Control register field positions
  localparam int unsigned BIT_WRITE_UNLOCK  = 0;
  localparam int unsigned BIT_WATCHDOG_ARM  = 1;
  localparam int unsigned BIT_TIMEOUT_FLAG  = 2;
  localparam int unsigned BIT_IRQ_SELECT    = 3;
  localparam int unsigned PRESCALE_LSB      = 4;
  localparam int unsigned PRESCALE_WIDTH    = 4;
  // Reset value of the control register
  localparam logic [7:0]  CONTROL_RESET     = 8'h00;
  // Prescale code that forces an immediate reset
  localparam logic [3:0]  PRESCALE_IMMEDIATE = 4'h8;
  // Highest prescale code with a timed period
  localparam logic [3:0]  PRESCALE_MAX_TIMED = 4'h7;
  // Crystal periods per unit of the timeout equation (2^9)
  localparam int unsigned BASE_TICKS_LOG2   = 9;
  // Tick counter width: 2^(7+9) ticks at the longest period
  localparam int unsigned TICK_COUNT_WIDTH  = 17;
  // Width of a watchdog reset pulse in core clocks
  localparam int unsigned RESET_PULSE_CYCLES = 1;
endpackage

// >>> hdl/watchdog_timeout_counter.sv
// Counts crystal ticks and flags a timeout per the prescale code.
// Assumes xtal_tick_i is a one-cycle pulse, one per crystal period.
`timescale 1ns/100ps
module watchdog_timeout_counter
  import watchdog_pkg::*;
(
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      run_i,
  input  wire logic                      restart_i,
  input  wire logic                      xtal_tick_i,
  input  wire logic [PRESCALE_WIDTH-1:0] prescale_i,
  output logic                           expired_o
);
  logic [TICK_COUNT_WIDTH-1:0] ticks;      // Elapsed crystal periods
  logic [TICK_COUNT_WIDTH-1:0] limit;      // Period in crystal periods

  // Limit is 2^prescale * 512 crystal periods
  // period from prescale
  always_comb begin
    limit = TICK_COUNT_WIDTH'(1) << (5'(prescale_i[2:0]) + 5'(BASE_TICKS_LOG2));
  end

  // Tick counter, cleared on restart or when stopped
  // restart on rearm
  always_ff @(posedge core_clk_i) begin
    if (rst_i || restart_i || !run_i || expired_o) begin
      ticks <= '0;
    end else if (xtal_tick_i) begin
      ticks <= ticks + TICK_COUNT_WIDTH'(1);
    end
  end

  // Expiry pulse, one cycle when the count reaches the limit
  always_ff @(posedge core_clk_i) begin
    if (rst_i || restart_i || !run_i) begin
      expired_o <= 1'b0;
    end else begin
      expired_o <= !expired_o && (ticks == limit - TICK_COUNT_WIDTH'(1)) && xtal_tick_i;
    end
  end
endmodule

// >>> verification/tb.sv
// Self-checking bench for the watchdog control block.
// Assumes the crystal tick runs fast, one pulse every two core clocks.
`timescale 1ns/100ps
module tb;
  import watchdog_pkg::*;
  logic       clk = 0, rst = 1, tick = 0, wr = 0, done = 0, mon = 0; // Bench drives
  logic [7:0] wd = 8'h00, rd;                                      // Write data, read image
  logic       irq, wrst;                                           // Timeout responses
  int         bad_count = 0, checks = 0, cyc = 0, n;               // Counters
  always #2 clk = ~clk;
  // Tick pulse and hang ceiling
  always @(posedge clk) begin
    tick <= ~tick;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end
  watchdog_control_bits uut (.core_clk_i(clk), .rst_i(rst), .xtal_tick_i(tick), .reg_write_i(wr),
    .instr_done_i(done), .reg_wdata_i(wd), .supply_monitor_i(mon), .reg_rdata_o(rd), .timeout_irq_o(irq),
    .watchdog_reset_o(wrst));
  task chk(string s, logic [7:0] e, logic [7:0] g);
    checks++;
    if (e !== g) begin
      bad_count++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // Unlock, write, then close at the instruction boundary
  task put(logic [7:0] d);
    @(posedge clk) begin wr <= 1; wd <= 8'h01; end
    @(posedge clk) wd <= d;
    @(posedge clk) begin wr <= 0; done <= 1; end
    @(posedge clk) done <= 0;
    @(posedge clk) #1;
  endtask
  task wait_ev(output int k);
    k = 0;
    while ((irq | wrst) !== 1'b1 && k < 5000) begin @(posedge clk) #1; k++; end
  endtask
  task t_locked();
    #1 chk("reset value", CONTROL_RESET, rd);
    @(posedge clk) done <= 1;
    @(posedge clk) begin done <= 0; wr <= 1; wd <= 8'h02; end
    @(posedge clk) wr <= 0;
    repeat (3) @(posedge clk);
    #1 chk("locked arm", 0, rd[1]);
    $display("t_locked end");
  endtask
  task t_irq();
    put(8'h0A);
    repeat (500) @(posedge clk);
    put(8'h0A);
    wait_ev(n);
    chk("irq", 1, irq);
    chk("period 0", 1, n inside {[1010:1030]});
    repeat (2) @(posedge clk);
    #1 chk("flag", 1, rd[2]);
    put(8'h08);
    chk("write 0", 0, rd[1]);
    $display("t_irq end");
  endtask
  task t_rst_mode();
    put(8'h12);
    wait_ev(n);
    chk("wd reset", 1, wrst);
    chk("period 1", 1, n inside {[2030:2060]});
    repeat (3) @(posedge clk);
    #1 chk("arm cleared", 8'h14, rd);
    $display("t_rst_mode end");
  endtask
  task t_monitor();
    put(8'h02);
    @(posedge clk) mon <= 1;
    @(posedge clk) mon <= 0;
    repeat (2) @(posedge clk);
    #1 chk("monitor arm", 0, rd[1]);
    @(posedge clk) begin wr <= 1; wd <= 8'h01; end
    @(posedge clk) wd <= 8'h82;
    @(posedge clk) begin wr <= 0; done <= 1; end
    @(posedge clk) done <= 0;
    #1 chk("immediate", 1, wrst);
    @(posedge clk) #1;
    chk("immediate arm", 0, rd[1]);
    @(posedge clk) rst <= 1;
    repeat (2) @(posedge clk);
    @(posedge clk) rst <= 0;
    #1 chk("hw reset", 0, rd[2]);
    $display("t_monitor end");
  endtask
  task print_verdict();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    t_locked();
    t_irq();
    t_rst_mode();
    t_monitor();
    print_verdict();
  end
endmodule

// >>> verification/watchdog_control_bits_sva.sv
// Port checker for the watchdog control block.
// Assumes the bind at the foot attaches it to every instance.
`timescale 1ns/100ps
module watchdog_control_bits_sva (
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic       xtal_tick_i,
  input wire logic       reg_write_i,
  input wire logic       instr_done_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       supply_monitor_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       timeout_irq_o,
  input wire logic       watchdog_reset_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_irq_needs_select: assert property (timeout_irq_o |-> reg_rdata_o[3])
    else $error("irq raised without select");
  a_flag_on_timeout: assert property (timeout_irq_o |-> ##[0:2] reg_rdata_o[2])
    else $error("flag not set on timeout");
  a_flag_stays_set: assert property (reg_rdata_o[2] |=> reg_rdata_o[2])
    else $error("flag dropped");
  a_arm_after_reset: assert property (watchdog_reset_o |-> ##[1:3] !reg_rdata_o[1])
    else $error("arm kept after watchdog reset");
  a_arm_on_monitor: assert property (supply_monitor_i |-> ##[1:3] !reg_rdata_o[1])
    else $error("arm kept after monitor event");
  a_write_locked: assert property (instr_done_i && !reg_write_i ##1 reg_write_i && reg_wdata_i == 8'h02
    && !reg_rdata_o[1] |=> ##1 !reg_rdata_o[1]) else $error("locked write taken");
  a_write_taken: assert property (reg_write_i && reg_wdata_i == 8'h01 && !instr_done_i ##1 reg_write_i
    && reg_wdata_i[1:0] == 2'b10 && !reg_wdata_i[7] && !supply_monitor_i
    |=> ##1 reg_rdata_o[1] && reg_rdata_o[7:4] == $past(reg_wdata_i[7:4], 2)) else $error("unlocked write lost");
  a_immediate_reset: assert property (reg_write_i && reg_wdata_i == 8'h01 && !instr_done_i ##1 reg_write_i
    && reg_wdata_i == 8'h82 |-> ##[1:3] watchdog_reset_o) else $error("no immediate reset");
endmodule
bind watchdog_control_bits watchdog_control_bits_sva chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .xtal_tick_i(xtal_tick_i), .reg_write_i(reg_write_i), .instr_done_i(instr_done_i), .reg_wdata_i(reg_wdata_i),
  .supply_monitor_i(supply_monitor_i), .reg_rdata_o(reg_rdata_o), .timeout_irq_o(timeout_irq_o),
  .watchdog_reset_o(watchdog_reset_o));
